//--- verilog/iar_pkg.sv
// What this block does
// - Indirect when current relocation flag asks
// - Branch-link-indirect operand names a control word unless on the I/O path or indirectAllowed is clear
// - I/O channel addresses never go indirect
// - Control words word aligned, protection checked
// - Examine flags byte before using address
// - Ignore top four flag bits
// - Trail examined only when absence, chain clear
// - Set trail cleared and flags written back
// - Write-back obeys protection, suppressed if denied
// - Absence clear: interpret flags and address
// - Absence set: raise indirect addressing exception
// - Store control word address at 18C bits 8-31
// - Leave top byte of 18C untouched
// - Relative clear means absolute address field
// - Relative set converts field to absolute
// - Chain bit ignored when absence set
// - Chain clear ends walk, object reached
// - Indexed format adds index after chain
// - Chain set fetches next control word
// - Low 24 bits hold the address
// - Ninth level request raises specification exception
// - First level relocation from relocation flags
//
// Purpose: constants and carrier types for the indirect address resolver
// Assumes: flag bit n of a byte is bit 7-n (bit 0 is most significant)
// Notes:   addresses are 24-bit absolute byte addresses
package iar_pkg;

  localparam int ADDR_W     = 24;
  localparam int WORD_W     = 32;
  localparam int MAX_LEVELS = 8;
  localparam int LEVEL_W    = 4;

  // flag bit numbers, most significant first
  localparam int CW_T_BIT = 4;
  localparam int CW_A_BIT = 5;
  localparam int CW_R_BIT = 6;
  localparam int CW_I_BIT = 7;
  localparam int RR_RI_BIT = 3;
  localparam int RR_DEST_IND_BIT = 4;
  localparam int RR_RD_BIT = 5;
  localparam int RR_IO_BIT = 6;
  localparam int RR_ORIG_REL_BIT = 7;

  localparam logic [ADDR_W-1:0] ABSENCE_REC_ADDR = 24'h00018c;
  localparam logic [3:0]        BE_FLAGS_BYTE    = 4'h8;
  localparam logic [3:0]        BE_ADDR_BYTES    = 4'h7;
  localparam logic [3:0]        BE_FULL_WORD     = 4'hf;
  localparam logic [7:0]        FLAGS_RESET      = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;        // D+(B), before relocation
    logic [ADDR_W-1:0] relocOffset;
    logic [7:0]        relocFlags;
    logic              isBranchLinkIndirect;
    logic              useDestination; // 1: destination operand, 0: origin
    logic              indirectAllowed;
    logic              ioPath;
    logic              indexed;
    logic [ADDR_W-1:0] indexValue;
  } iar_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              newRelInstr;   // for branch-link-indirect: new RI value
    logic              absenceExc;
    logic              specExc;
    logic              protExc;
    logic              wbDenied;
    logic [LEVEL_W-1:0] levels;
  } iar_resp_t;

endpackage : iar_pkg

//--- verilog/iar_reloc_add.sv
// Purpose: relative-to-absolute conversion and index add
// Assumes: addition wraps modulo the address width
// Notes:   purely combinational; caller registers the result
`timescale 1ns/1ps
module iar_reloc_add #(
  parameter int WIDTH = iar_pkg::ADDR_W
) (
  // operands
  input  wire logic [WIDTH-1:0] base,
  input  wire logic [WIDTH-1:0] offset,
  input  wire logic             relative,
  input  wire logic [WIDTH-1:0] index,
  input  wire logic             indexed,
  // result
  output logic      [WIDTH-1:0] conv,
  output logic      [WIDTH-1:0] convIndexed
);
  initial begin
    if (WIDTH < 3) $error("iar_reloc_add: WIDTH too small");
  end

  always_comb begin
    conv        = relative ? WIDTH'(base + offset) : base;
    convIndexed = indexed ? WIDTH'(conv + index) : conv;
  end
endmodule // iar_reloc_add

//--- verilog/iar_resolver.sv
// Purpose: walk indirect address control word chains to a final address
// Assumes: storage answers each request with one memAck pulse, plus a
//          protection denial flag in the same cycle
// Notes:   one request at a time; reqReady only while idle
`timescale 1ns/1ps
module iar_resolver #(
  parameter int MAX_LEVELS = iar_pkg::MAX_LEVELS
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // execution side
  input  wire logic                        reqValid,
  input  wire iar_pkg::iar_req_t           req,
  output logic                             reqReady,
  output logic                             respValid,
  output iar_pkg::iar_resp_t               resp,
  // main storage through protection
  output logic                             memReq,
  output logic                             memWe,
  output logic [iar_pkg::ADDR_W-1:0]       memAddr,
  output logic [iar_pkg::WORD_W-1:0]       memWdata,
  output logic [3:0]                       memByteEn,
  input  wire logic                        memAck,
  input  wire logic [iar_pkg::WORD_W-1:0]  memRdata,
  input  wire logic                        memProtDeny
);
  initial begin
    if (MAX_LEVELS < 1 || MAX_LEVELS >= (1 << iar_pkg::LEVEL_W))
      $error("iar_resolver: MAX_LEVELS out of range");
  end

  localparam int AW = iar_pkg::ADDR_W;
  localparam int LW = iar_pkg::LEVEL_W;

  // bit n of a flags byte, numbered from the most significant end
  function automatic logic flagBit(input logic [7:0] flags, input int n);
    flagBit = flags[7-n];
  endfunction

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_READ  = 5'h02,
    ST_WBACK = 5'h04,
    ST_EXREC = 5'h08,
    ST_DONE  = 5'h10
  } iar_state_t;

  iar_state_t                 state_reg, state_next;
  logic [AW-1:0]              ptr_reg;
  logic [iar_pkg::LEVEL_W-1:0] level_reg;
  logic [7:0]                 cwFlags_reg;
  logic [AW-1:0]              cwAddr_reg;
  logic [AW-1:0]              offset_reg;
  logic [AW-1:0]              index_reg;
  logic                       indexed_reg;
  iar_pkg::iar_resp_t         resp_reg;

  // decode of the word just read; bits 0-3 never looked at
  logic [7:0]    rdFlags;
  logic [AW-1:0] rdAddr;
  logic          rdAbsent, rdRel, rdChain, rdTrail;
  assign rdFlags  = memRdata[31:24];
  assign rdAddr   = memRdata[AW-1:0];
  assign rdAbsent = flagBit(rdFlags, iar_pkg::CW_A_BIT);
  assign rdRel    = flagBit(rdFlags, iar_pkg::CW_R_BIT);
  assign rdChain  = flagBit(rdFlags, iar_pkg::CW_I_BIT);
  assign rdTrail  = flagBit(rdFlags, iar_pkg::CW_T_BIT);

  // first level: relocation and indirection choice
  logic          firstRel, goIndirect;
  logic [AW-1:0] firstAddr, firstIndexed;
  always_comb begin
    if (req.isBranchLinkIndirect)
      firstRel = flagBit(req.relocFlags, iar_pkg::RR_RI_BIT);
    else if (req.useDestination)
      firstRel = flagBit(req.relocFlags, iar_pkg::RR_RD_BIT);
    else
      firstRel = flagBit(req.relocFlags, iar_pkg::RR_ORIG_REL_BIT);
    if (req.ioPath || !req.indirectAllowed)
      goIndirect = 1'b0;
    else if (req.isBranchLinkIndirect)
      goIndirect = 1'b1;
    else if (req.useDestination)
      goIndirect = flagBit(req.relocFlags, iar_pkg::RR_DEST_IND_BIT);
    else
      goIndirect = flagBit(req.relocFlags, iar_pkg::RR_IO_BIT);
  end

  iar_reloc_add #(.WIDTH(AW)) u_first (
    .base        (req.addr),
    .offset      (req.relocOffset),
    .relative    (firstRel),
    .index       (req.indexValue),
    .indexed     (req.indexed),
    .conv        (firstAddr),
    .convIndexed (firstIndexed)
  );

  // chain level: address field under control of its own relative bit
  logic [AW-1:0] cwConv, cwFinal;
  iar_reloc_add #(.WIDTH(AW)) u_chain (
    .base        (rdAddr),
    .offset      (offset_reg),
    .relative    (rdRel),
    .index       (index_reg),
    .indexed     (indexed_reg),
    .conv        (cwConv),
    .convIndexed (cwFinal)
  );

  logic accept, rdDone, wrDone;
  assign accept = reqValid && reqReady;
  assign rdDone = (state_reg == ST_READ) && memAck;
  assign wrDone = ((state_reg == ST_WBACK) || (state_reg == ST_EXREC)) && memAck;

  // sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept)
          state_next = (goIndirect && firstAddr[1:0] == 2'b00) ? ST_READ : ST_DONE;
      end
      ST_READ: begin
        if (memAck) begin
          if (memProtDeny)
            state_next = ST_DONE;
          else if (rdAbsent)
            state_next = ST_EXREC;
          else if (rdChain)
            state_next = (level_reg >= LW'(MAX_LEVELS) ||
                          cwConv[1:0] != 2'b00) ? ST_DONE : ST_READ;
          else if (rdTrail)
            state_next = ST_WBACK;
          else
            state_next = ST_DONE;
        end
      end
      ST_WBACK: begin
        if (memAck)
          state_next = ST_DONE;
      end
      ST_EXREC: begin
        if (memAck)
          state_next = ST_DONE;
      end
      ST_DONE:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // walk pointer, level count and captured request context
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_reg     <= '0;
      level_reg   <= '0;
      offset_reg  <= '0;
      index_reg   <= '0;
      indexed_reg <= 1'b0;
    end else if (accept) begin
      ptr_reg     <= firstAddr;
      level_reg   <= LW'(1);
      offset_reg  <= req.relocOffset;
      index_reg   <= req.indexValue;
      indexed_reg <= req.indexed;
    end else if (rdDone && !memProtDeny && !rdAbsent && rdChain) begin
      ptr_reg   <= cwConv;
      level_reg <= level_reg + LW'(1);
    end
  end

  // last control word held for the trail write-back
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cwFlags_reg <= iar_pkg::FLAGS_RESET;
      cwAddr_reg  <= '0;
    end else if (rdDone) begin
      cwFlags_reg <= rdFlags;
      cwAddr_reg  <= rdAddr;
    end
  end

  // result; cleared on every new request so stale flags never leak
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      resp_reg <= '0;
    end else if (accept) begin
      resp_reg          <= '0;
      resp_reg.addr     <= firstIndexed;
      resp_reg.specExc  <= goIndirect && firstAddr[1:0] != 2'b00;
      resp_reg.newRelInstr <= flagBit(req.relocFlags, iar_pkg::RR_RI_BIT);
    end else if (rdDone) begin
      resp_reg.levels <= level_reg;
      if (memProtDeny) begin
        resp_reg.protExc <= 1'b1;
      end else if (rdAbsent) begin
        resp_reg.absenceExc <= 1'b1;
      end else if (rdChain) begin
        if (level_reg >= LW'(MAX_LEVELS) || cwConv[1:0] != 2'b00)
          resp_reg.specExc <= 1'b1;
      end else begin
        resp_reg.addr        <= cwFinal;
        resp_reg.newRelInstr <= rdRel;
      end
    end else if (state_reg == ST_WBACK && memAck) begin
      resp_reg.wbDenied <= memProtDeny;
    end
  end

  // storage requests: read, trail write-back, absence record
  always_comb begin
    memReq    = 1'b0;
    memWe     = 1'b0;
    memAddr   = ptr_reg;
    memWdata  = '0;
    memByteEn = iar_pkg::BE_FULL_WORD;
    case (state_reg)
      ST_READ: begin
        memReq = 1'b1;
      end
      ST_WBACK: begin
        memReq    = 1'b1;
        memWe     = 1'b1;
        memWdata  = {cwFlags_reg & ~(8'h80 >> iar_pkg::CW_T_BIT), cwAddr_reg};
        memByteEn = iar_pkg::BE_FLAGS_BYTE;
      end
      ST_EXREC: begin
        memReq    = 1'b1;
        memWe     = 1'b1;
        memAddr   = iar_pkg::ABSENCE_REC_ADDR;
        memWdata  = {8'h00, ptr_reg};
        memByteEn = iar_pkg::BE_ADDR_BYTES;
      end
      default: ;
    endcase
  end

  assign reqReady  = (state_reg == ST_IDLE);
  assign respValid = (state_reg == ST_DONE);
  assign resp      = resp_reg;

  // checks
  a_wb_trail_clear: assert property (@(posedge clk) disable iff (!rst_b)
    memReq && memWe && state_reg == ST_WBACK |->
      !memWdata[31-iar_pkg::CW_T_BIT] && memByteEn == 4'h8
      && memWdata[31:24] == (cwFlags_reg & 8'hf7) && cwFlags_reg[7-iar_pkg::CW_T_BIT])
    else $error("trail write-back word wrong");

  a_absence_record: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && !memProtDeny && rdAbsent |=>
      memReq && memWe && memAddr == 24'h00018c && memByteEn == 4'h7
      && memWdata[23:0] == $past(ptr_reg))
    else $error("absence record not issued");

  a_absence_resp: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && !memProtDeny && rdAbsent |=> ##[0:40] respValid && resp.absenceExc)
    else $error("absence exception not raised");

  a_io_direct: assert property (@(posedge clk) disable iff (!rst_b)
    accept && req.ioPath |=> respValid && !memReq)
    else $error("i/o address went indirect");

  a_bli_indirect: assert property (@(posedge clk) disable iff (!rst_b)
    accept && req.isBranchLinkIndirect && !req.ioPath && req.indirectAllowed
      && firstAddr[1:0] == 2'b00 |=> memReq && !memWe)
    else $error("branch-link-indirect did not fetch");

  a_level_limit: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && !memProtDeny && !rdAbsent && rdChain && level_reg == 4'(MAX_LEVELS)
      |=> respValid && resp.specExc)
    else $error("chain limit not enforced");

  a_no_wb_on_chain: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && (rdAbsent || rdChain) |=> state_reg != ST_WBACK)
    else $error("trail acted on while ignored");

  a_wb_before_done: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && !memProtDeny && !rdAbsent && !rdChain && rdTrail
      |=> state_reg == ST_WBACK ##[1:40] respValid)
    else $error("result before write-back");

  a_read_aligned: assert property (@(posedge clk) disable iff (!rst_b)
    memReq && !memWe |-> memAddr[1:0] == 2'b00)
    else $error("unaligned control word read");

  a_final_addr: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && !memProtDeny && !rdAbsent && !rdChain && !rdTrail
      |=> respValid && resp.addr == $past(cwFinal))
    else $error("final address wrong");

  // storage handshake, early exits and result pulse
  a_req_stable: assert property (@(posedge clk) disable iff (!rst_b)
    memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe) && $stable(memWdata))
    else $error("storage request changed before acknowledge");

  a_first_read: assert property (@(posedge clk) disable iff (!rst_b)
    accept && goIndirect && firstAddr[1:0] == 2'b00 |=> memReq && memAddr == $past(firstAddr))
    else $error("first control word address wrong");

  a_misalign_spec: assert property (@(posedge clk) disable iff (!rst_b)
    accept && goIndirect && firstAddr[1:0] != 2'b00 |=> respValid && resp.specExc && !memReq)
    else $error("misaligned control word not refused");

  a_direct_index: assert property (@(posedge clk) disable iff (!rst_b)
    accept && !goIndirect |=> respValid && resp.addr == $past(firstIndexed))
    else $error("direct address wrong");

  a_prot_read_end: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && memProtDeny |=> respValid && resp.protExc && !memReq)
    else $error("refused read did not end the walk");

  a_wb_denied: assert property (@(posedge clk) disable iff (!rst_b)
    wrDone && state_reg == ST_WBACK && memProtDeny |=> respValid && resp.wbDenied)
    else $error("refused write-back not flagged");

  a_absent_no_chain: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && !memProtDeny && rdAbsent |=> state_reg == ST_EXREC && ptr_reg == $past(ptr_reg))
    else $error("chain followed from an absent word");

  a_trail_kept: assert property (@(posedge clk) disable iff (!rst_b)
    rdDone && !memProtDeny && !rdAbsent && !rdChain && !rdTrail |=> state_reg == ST_DONE)
    else $error("clear trail bit written back");

  a_resp_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    respValid |=> !respValid && reqReady)
    else $error("result pulse longer than one cycle");

  c_chain_two: cover property (@(posedge clk) disable iff (!rst_b)
    rdDone && rdChain && !rdAbsent ##[1:20] rdDone && !rdChain);
  c_trail_wb: cover property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_WBACK && memAck);
  c_absence: cover property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_EXREC && memAck);
  c_spec: cover property (@(posedge clk) disable iff (!rst_b)
    respValid && resp.specExc);
  c_wb_denied: cover property (@(posedge clk) disable iff (!rst_b)
    respValid && resp.wbDenied);
endmodule // iar_resolver

//--- verif/iar_mem_model.sv
// Purpose: main storage behind protection, as seen by the resolver
// Assumes: word array indexed by address bits 11:2; one access answered at a time
// Notes:   read data is inverted every idle cycle so stale data never looks valid
`timescale 1ns/1ps
module iar_mem_model (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // storage side of the resolver
  input  wire logic                       memReq,
  input  wire logic                       memWe,
  input  wire logic [iar_pkg::ADDR_W-1:0] memAddr,
  input  wire logic [iar_pkg::WORD_W-1:0] memWdata,
  input  wire logic [3:0]                 memByteEn,
  output logic                            memAck,
  output logic [iar_pkg::WORD_W-1:0]      memRdata,
  output logic                            memProtDeny,
  // test controls: 1 refuses reads, 2 refuses writes at denyAddr
  input  wire logic                       slow,
  input  wire logic [iar_pkg::ADDR_W-1:0] denyAddr,
  input  wire logic [1:0]                 denyKind
);
  logic [31:0] mem [0:1023];
  logic [1:0]  waitCnt;
  logic        deny;
  int          nAccess = 0;

  assign deny = (memAddr == denyAddr) &&
                ((denyKind == 2'h1 && !memWe) || (denyKind == 2'h2 && memWe));

  always @(negedge clk) begin
    memAck      <= 1'b0;
    memProtDeny <= 1'b0;
    memRdata    <= ~memRdata;
    if (!rst_b) begin
      waitCnt  <= 2'h0;
      memRdata <= 32'h00000000;
    end else if (memReq && !memAck) begin
      if (waitCnt >= (slow ? 2'h2 : 2'h0)) begin
        waitCnt     <= 2'h0;
        memAck      <= 1'b1;
        nAccess     <= nAccess + 1;
        memProtDeny <= deny;
        if (!memWe && !deny) begin
          memRdata <= mem[memAddr[11:2]];
        end
        // a refused write leaves the word as it was
        if (memWe && !deny) begin
          for (int b = 0; b < 4; b++) begin
            if (memByteEn[b]) begin
              mem[memAddr[11:2]][8*b+:8] <= memWdata[8*b+:8];
            end
          end
        end
      end else begin
        waitCnt <= waitCnt + 2'h1;
      end
    end
  end
endmodule // iar_mem_model

//--- verif/tb_top.sv
// Purpose: self-checking bench for the indirect address resolver
// Assumes: requests held from a falling edge until the accepting rising edge
// Notes:   expected addresses are worked out by hand from offsets and flags
`timescale 1ns/1ps
module tb_top;
  logic                         clk;
  logic                         rst_b;
  logic                         reqValid;
  iar_pkg::iar_req_t            req;
  logic                         reqReady;
  logic                         respValid;
  iar_pkg::iar_resp_t           resp;
  iar_pkg::iar_resp_t           got;
  logic                         memReq;
  logic                         memWe;
  logic [iar_pkg::ADDR_W-1:0]   memAddr;
  logic [iar_pkg::WORD_W-1:0]   memWdata;
  logic [3:0]                   memByteEn;
  logic                         memAck;
  logic [iar_pkg::WORD_W-1:0]   memRdata;
  logic                         memProtDeny;
  logic                         slow;
  logic [iar_pkg::ADDR_W-1:0]   denyAddr;
  logic [1:0]                   denyKind;
  int                           nMismatch = 0;
  int                           checks = 0;
  int                           n0;
  // relocation flag masks, bit n of the byte sits at [7-n]
  localparam logic [7:0] RI = 8'h10, DEST_IND = 8'h08, RD = 8'h04, IO = 8'h02, ORIG_REL = 8'h01;

  iar_resolver #(.MAX_LEVELS(8)) u_dut (
    .clk(clk), .rst_b(rst_b), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .respValid(respValid), .resp(resp), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memByteEn(memByteEn), .memAck(memAck),
    .memRdata(memRdata), .memProtDeny(memProtDeny));
  iar_mem_model u_mem (
    .clk(clk), .rst_b(rst_b), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memByteEn(memByteEn), .memAck(memAck), .memRdata(memRdata),
    .memProtDeny(memProtDeny), .slow(slow), .denyAddr(denyAddr), .denyKind(denyKind));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // kind = {indirectAllowed, branch link indirect, destination, io path, indexed}
  function automatic iar_pkg::iar_req_t mk(input logic [23:0] a, input logic [23:0] off,
                                           input logic [7:0] rf, input logic [4:0] kind,
                                           input logic [23:0] idx);
    iar_pkg::iar_req_t r;
    r = '0;
    r.addr = a;
    r.relocOffset = off;
    r.relocFlags = rf;
    {r.indirectAllowed, r.isBranchLinkIndirect, r.useDestination, r.ioPath, r.indexed} = kind;
    r.indexValue = idx;
    return r;
  endfunction

  function automatic logic [31:0] al();
    return {got.addr, 4'h0, got.levels};
  endfunction
  // {absence, specification, protection, write-back denied, new RI}
  function automatic logic [31:0] fx();
    return {27'h0, got.absenceExc, got.specExc, got.protExc, got.wbDenied, got.newRelInstr};
  endfunction
  function automatic logic [31:0] mw(input logic [23:0] a);
    return u_mem.mem[a[11:2]];
  endfunction
  task automatic put(input logic [23:0] a, input logic [7:0] f, input logic [23:0] v);
    u_mem.mem[a[11:2]] = {f, v};
  endtask

  task automatic run(input iar_pkg::iar_req_t r);
    int n;
    @(negedge clk);
    n0 = u_mem.nAccess;
    req = r;
    reqValid = 1'b1;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    reqValid = 1'b0;
    chk({31'h0, reqReady}, 32'h0);
    n = 0;
    while (respValid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, respValid}, 32'h1);
    got = resp;
  endtask

  initial begin
    #80000;
    nMismatch++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    reqValid = 1'b0;
    req = '0;
    slow = 1'b0;
    denyAddr = 24'h000000;
    denyKind = 2'h0;
    repeat (6) @(negedge clk);
    chk({30'h0, respValid, memReq}, 32'h0);
    chk({31'h0, reqReady}, 32'h1);
    rst_b = 1'b1;
    // direct: offset and index added, no storage access
    run(mk(24'h000100, 24'h001000, RD, 5'b10101, 24'h000005));
    chk(al(), {24'h001105, 8'h00});
    chk(u_mem.nAccess - n0, 32'h0);
    // io path never indirect
    run(mk(24'h000100, 24'h000000, DEST_IND, 5'b10110, 24'h000000));
    chk({28'h0, got.levels}, 32'h0);
    chk(u_mem.nAccess - n0, 32'h0);
    // one level, trail set, relative, top flag bits set
    put(24'h000240, 8'hfa, 24'h000010);
    run(mk(24'h000040, 24'h000200, DEST_IND | RD, 5'b10101, 24'h000003));
    chk(al(), {24'h000213, 8'h01});
    chk(fx(), 32'h01);
    chk(mw(24'h000240), {8'hf2, 24'h000010});
    chk(u_mem.nAccess - n0, 32'h2);
    // three level origin chain on slow storage, trail ignored under chain
    slow = 1'b1;
    put(24'h000300, 8'h09, 24'h000310);
    put(24'h000310, 8'h03, 24'h000020);
    put(24'h000320, 8'h00, 24'h000abc);
    run(mk(24'h000000, 24'h000300, IO | ORIG_REL, 5'b10000, 24'h000000));
    chk(al(), {24'h000abc, 8'h03});
    chk(mw(24'h000300), {8'h09, 24'h000310});
    chk(u_mem.nAccess - n0, 32'h3);
    slow = 1'b0;
    // absence: record address, keep top byte, no trail update
    put(24'h00018c, 8'h5a, 24'hffffff);
    put(24'h000400, 8'h0f, 24'h000123);
    run(mk(24'h000400, 24'h000000, DEST_IND, 5'b10100, 24'h000000));
    chk(fx(), 32'h10);
    chk(mw(24'h00018c), {8'h5a, 24'h000400});
    chk(mw(24'h000400), {8'h0f, 24'h000123});
    // eight levels allowed, a ninth request refused
    for (int k = 0; k < 8; k++) begin
      put(24'h000500 + 24'(4 * k), 8'h01, 24'h000504 + 24'(4 * k));
    end
    put(24'h00051c, 8'h00, 24'h000777);
    run(mk(24'h000500, 24'h000000, DEST_IND, 5'b10100, 24'h000000));
    chk(al(), {24'h000777, 8'h08});
    put(24'h00051c, 8'h01, 24'h000777);
    run(mk(24'h000500, 24'h000000, DEST_IND, 5'b10100, 24'h000000));
    chk(fx(), 32'h08);
    chk({28'h0, got.levels}, 32'h8);
    // branch link indirect: first level by RI, index on branch address
    put(24'h000700, 8'h02, 24'h000050);
    run(mk(24'h000600, 24'h000100, RI, 5'b11001, 24'h000002));
    chk(al(), {24'h000152, 8'h01});
    chk(fx(), 32'h01);
    // write-back refused: address still given, word unchanged
    put(24'h000800, 8'h08, 24'h000030);
    denyAddr = 24'h000800;
    denyKind = 2'h2;
    run(mk(24'h000800, 24'h000000, DEST_IND, 5'b10100, 24'h000000));
    chk(al(), {24'h000030, 8'h01});
    chk(fx(), 32'h02);
    chk(mw(24'h000800), {8'h08, 24'h000030});
    // read refused
    denyKind = 2'h1;
    run(mk(24'h000800, 24'h000000, DEST_IND, 5'b10100, 24'h000000));
    chk(fx(), 32'h04);
    denyKind = 2'h0;
    // misaligned control word: no access
    run(mk(24'h000802, 24'h000000, DEST_IND, 5'b10100, 24'h000000));
    chk(fx(), 32'h08);
    chk(u_mem.nAccess - n0, 32'h0);
    report_and_stop();
  end
endmodule // tb_top
